// ===== psm_regs.svh
// Constants for the polled star disk port multiplexer.
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH

// Port population: three local ports, three expanders of four ports.
`define PSM_NUM_CHAN 15
`define PSM_LOCAL_PORTS 4'h3
`define PSM_EXP_PORTS 4
`define PSM_NUM_EXP 3
`define PSM_FIRST_CHAN 4'h0
`define PSM_LAST_CHAN 4'he

// Timing of the regenerated read strobe halves.
`define PSM_CLK_PERIOD_NS 25
`define PSM_HALF_STROBE_NS 100
`define PSM_HALF_CYC \
	((`PSM_HALF_STROBE_NS + `PSM_CLK_PERIOD_NS - 1) / `PSM_CLK_PERIOD_NS)
`define PSM_STROBE_CYC (2 * `PSM_HALF_CYC)

// Depth of the write data buffer toward the controller.
`define PSM_FIFO_DEPTH 4

`endif

// ===== psm_pkg.sv
// Types shared by the multiplexer, its expanders and the write buffer.
package psm_pkg;

	// Signals arriving from one host port.
	typedef struct packed {
		logic       port_request;
		logic       reset_pulse;
		logic [3:0] host_write_nibble;
		logic       host_write_strobe;
		logic       write_parity_bit;
		logic       second_drive_flag;
		logic       processor_busy;
	} psm_host_in_t;

	// Signals driven toward one host port.
	typedef struct packed {
		logic       ack;
		logic [3:0] host_read_nibble;
		logic       host_read_strobe;
		logic       host_disk_ready_busy;
	} psm_host_out_t;

	// Signals arriving from the disk controller.
	typedef struct packed {
		logic       controller_read_strobe;
		logic [7:0] read_byte_bus;
		logic       controller_ready_busy;
		logic       controller_write_ready;
	} psm_ctl_in_t;

	// One buffered write byte with its parity.
	typedef struct packed {
		logic       write_parity_bit;
		logic [7:0] byte_val;
	} psm_wr_word_t;

	// Poller states.
	typedef enum logic {
		PSM_SCAN,
		PSM_GRANT
	} psm_poll_state_t;

endpackage

// ===== psm_fifo.sv
// Small FIFO with registered read data and valid/ready on both sides.
`include "psm_regs.svh"

module psm_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = `PSM_FIFO_DEPTH
) (
	input  logic             sys_clk,
	input  logic             rst_n,
	input  logic             in_valid,
	output logic             in_ready,
	input  logic [WIDTH-1:0] in_data,
	output logic             out_valid,
	input  logic             out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;
	logic             push;
	logic             pop;

	// Space is honest: the output stage refills from the memory.
	assign in_ready  = (count_reg != (AW + 1)'(DEPTH));
	assign push      = in_valid && in_ready;
	assign pop       = (count_reg != '0) && (!out_valid_reg || out_ready);
	assign out_valid = out_valid_reg;
	assign out_data  = out_data_reg;

	// Storage array, written without reset.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers, occupancy and the registered output stage.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= '0;
			count_reg     <= '0;
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg    <= rd_ptr_reg + AW'(1);
				out_data_reg  <= mem_reg[rd_ptr_reg];
				out_valid_reg <= 1'b1;
			end else if (out_ready) begin
				out_valid_reg <= 1'b0;
			end
			count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

endmodule // psm_fifo

// ===== psm_expander.sv
// Expander board: four host ports, port decode, reset pick, request latch.
`include "psm_regs.svh"

module psm_expander
	import psm_pkg::*;
(
	input  logic                     sys_clk,
	input  logic                     rst_n,
	input  logic [1:0]               port_code,
	input  logic                     board_granted,
	input  psm_host_in_t [3:0]       host_in,
	input  psm_host_out_t            read_out,
	output logic [3:0]               port_enable_n,
	output logic [3:0]               port_request_line,
	output psm_host_in_t             selected,
	output psm_host_out_t [3:0]      host_out
);
	logic [3:0] req_latch_reg;

	// One enable low out of four, from the port code.
	assign port_enable_n = ~(4'h1 << port_code);

	// The addressed port feeds reset, write data and status upward.
	assign selected = host_in[port_code];

	assign port_request_line = req_latch_reg;

	// Request latch, clocked by the free-running clock.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_latch_reg <= 4'h0;
		end else begin
			for (int i = 0; i < `PSM_EXP_PORTS; i++) begin
				req_latch_reg[i] <= host_in[i].port_request;
			end
		end
	end

	// Read data, strobe, ready and acknowledge reach only the enabled port.
	for (genvar g = 0; g < `PSM_EXP_PORTS; g++) begin : g_out
		assign host_out[g] = (board_granted && !port_enable_n[g]) ?
			read_out : '0;
	end

endmodule // psm_expander

// ===== psm_mux_top.sv
// Master board: poller, decode, nibble paths, status and write buffer.
// Operation
// - Expander decodes port code to one enable.
// - Expander forwards selected host reset as prime.
// - Expander latches each host request separately.
// - Read low nibble first, high nibble second.
// - Write nibbles latched low half then high.
// - Poller scans requests, acknowledges one port.
// - Poller holds while a grant stands.
// - Scanning resumes at the next channel.
// - Reset sets poller to first master port.
// - Clock steps poller and request latches.
// - Grant decodes board select, enables, port code.
// - Master decodes port code into local enables.
// - Addressed host reset drives controller prime.
// - Granted host busy goes to controller.
// - Controller read strobe resent to granted host.
// - Second drive flag carried from granted port.
// - Parity bit carried alongside write data.
// - Controller ready/busy relayed to granted host.
// - Host write strobe forwarded to controller.
// - Three local ports plus three expanders.
`include "psm_regs.svh"

module psm_mux_top
	import psm_pkg::*;
(
	input  logic                               sys_clk,
	input  logic                               rst_n,
	input  psm_host_in_t [`PSM_NUM_CHAN-1:0]   host_in,
	input  logic                               controller_read_strobe,
	input  logic [7:0]                         read_byte_bus,
	input  logic                               controller_ready_busy,
	input  logic                               controller_write_ready,
	output psm_host_out_t [`PSM_NUM_CHAN-1:0]  host_out,
	output logic                               controller_prime,
	output logic                               controller_host_status,
	output logic                               second_drive_flag,
	output logic [7:0]                         disk_write_byte,
	output logic                               write_parity_bit,
	output logic                               controller_write_strobe,
	output logic [3:0]                         board_select_line,
	output logic [1:0]                         port_code,
	output logic [2:0]                         local_port_enable_n
);

	////////////////////////////////////////////////////////////////////
	// Channel arithmetic.

	// Next channel in round-robin order, wrapping after the last.
	function automatic logic [3:0] next_chan(input logic [3:0] c);
		if (c == `PSM_LAST_CHAN) begin
			return `PSM_FIRST_CHAN;
		end
		return c + 4'h1;
	endfunction

	// Board of a channel: zero is the master, then expanders.
	function automatic logic [1:0] chan_board(input logic [3:0] c);
		if (c < `PSM_LOCAL_PORTS) begin
			return 2'h0;
		end
		return 2'(((c - `PSM_LOCAL_PORTS) >> 2) + 4'h1);
	endfunction

	// Port of a channel within its board.
	function automatic logic [1:0] chan_port(input logic [3:0] c);
		if (c < `PSM_LOCAL_PORTS) begin
			return c[1:0];
		end
		return 2'(c - `PSM_LOCAL_PORTS);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers.

	logic                              rst_meta_reg;
	logic                              rst_sync_n_reg;
	psm_host_in_t [`PSM_NUM_CHAN-1:0]  hin_meta_reg;
	psm_host_in_t [`PSM_NUM_CHAN-1:0]  hin_sync_reg;
	psm_ctl_in_t                       ctl_meta_reg;
	psm_ctl_in_t                       ctl_sync_reg;

	// Reset is asserted at once and released through two flip-flops.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg   <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end else begin
			rst_meta_reg   <= 1'b1;
			rst_sync_n_reg <= rst_meta_reg;
		end
	end

	// Every host and controller input passes two flip-flops.
	always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			hin_meta_reg <= '0;
			hin_sync_reg <= '0;
			ctl_meta_reg <= '0;
			ctl_sync_reg <= '0;
		end else begin
			hin_meta_reg <= host_in;
			hin_sync_reg <= hin_meta_reg;
			ctl_meta_reg <= {controller_read_strobe, read_byte_bus,
				controller_ready_busy, controller_write_ready};
			ctl_sync_reg <= ctl_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Poller and decode.

	psm_poll_state_t        state_reg;
	psm_poll_state_t        state_next;
	logic [3:0]             chan_reg;
	logic [3:0]             chan_next;
	logic [2:0]             loc_req_reg;
	logic [3:0]             exp_req [`PSM_NUM_EXP];
	logic [`PSM_NUM_CHAN-1:0] req_all;
	logic                   granted;
	logic                   prime;
	logic [1:0]             board_w;
	logic [1:0]             port_code_w;
	logic [1:0]             loc_idx;
	logic [2:0]             loc_en_w;
	psm_host_in_t           loc_sel;
	psm_host_in_t           exp_sel [`PSM_NUM_EXP];
	psm_host_in_t           sel_host;

	// Fifteen request lines: master ports first, then each expander.
	assign req_all = {exp_req[2], exp_req[1], exp_req[0], loc_req_reg};

	// Decode of the current channel into board and port code.
	assign granted     = (state_reg == PSM_GRANT);
	assign board_w     = chan_board(chan_reg);
	assign port_code_w = chan_port(chan_reg);
	assign loc_idx     = (port_code_w == 2'h3) ? 2'h0 : port_code_w;
	assign loc_en_w    = (granted && board_w == 2'h0) ?
		(3'h1 << port_code_w) : 3'h0;
	assign loc_sel     = hin_sync_reg[loc_idx];

	// Host signals of the addressed port, from master or expander.
	assign sel_host = (board_w == 2'h0) ? loc_sel :
		(board_w == 2'h1) ? exp_sel[0] :
		(board_w == 2'h2) ? exp_sel[1] : exp_sel[2];

	// The addressed host's reset primes controller and poller.
	assign prime = sel_host.reset_pulse;

	// Local request latch on the free-running clock.
	always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			loc_req_reg <= 3'h0;
		end else begin
			for (int i = 0; i < `PSM_LOCAL_PORTS; i++) begin
				loc_req_reg[i] <= hin_sync_reg[i].port_request;
			end
		end
	end

	// Scan one channel per clock, stop on a request, resume after it.
	always_comb begin
		state_next = state_reg;
		chan_next  = chan_reg;
		if (prime) begin
			state_next = PSM_SCAN;
			chan_next  = `PSM_FIRST_CHAN;
		end else begin
			case (state_reg)
				PSM_SCAN: begin
					if (req_all[chan_reg]) begin
						state_next = PSM_GRANT;
					end else begin
						chan_next = next_chan(chan_reg);
					end
				end
				PSM_GRANT: begin
					if (!req_all[chan_reg]) begin
						state_next = PSM_SCAN;
						chan_next  = next_chan(chan_reg);
					end
				end
				default: begin
					state_next = PSM_SCAN;
				end
			endcase
		end
	end

	// Poller state; the grant holds the count still.
	always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			state_reg <= PSM_SCAN;
			chan_reg  <= `PSM_FIRST_CHAN;
		end else begin
			state_reg <= state_next;
			chan_reg  <= chan_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path: strobe regeneration and nibble multiplexing.

	logic        rd_strobe_d_reg;
	logic [7:0]  rd_byte_reg;
	logic [3:0]  rd_cnt_reg;
	logic        rd_rise;
	logic        rd_active;
	logic        nibble_select;
	logic [3:0]  rd_nib;
	logic        fifo_in_ready;
	psm_host_out_t rd_out;

	// Each controller strobe starts one two-half host strobe.
	assign rd_rise   = ctl_sync_reg.controller_read_strobe &&
		!rd_strobe_d_reg;
	assign rd_active = (rd_cnt_reg != 4'h0);

	// Second half once the count is down to one half.
	assign nibble_select = (rd_cnt_reg <= 4'(`PSM_HALF_CYC));
	assign rd_nib = nibble_select ? rd_byte_reg[7:4] :
		rd_byte_reg[3:0];

	// Ready only while the disk is ready and the buffer has room.
	assign rd_out = {granted, rd_nib, rd_active,
		ctl_sync_reg.controller_ready_busy && fifo_in_ready};

	// Capture the byte and time the regenerated strobe.
	always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			rd_strobe_d_reg <= 1'b0;
			rd_byte_reg     <= 8'h00;
			rd_cnt_reg      <= 4'h0;
		end else begin
			rd_strobe_d_reg <= ctl_sync_reg.controller_read_strobe;
			if (rd_rise) begin
				rd_byte_reg <= ctl_sync_reg.read_byte_bus;
				rd_cnt_reg  <= 4'(`PSM_STROBE_CYC);
			end else if (rd_active) begin
				rd_cnt_reg <= rd_cnt_reg - 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Expander boards and host-facing outputs.

	psm_host_out_t [3:0] exp_out [`PSM_NUM_EXP];
	psm_host_out_t [2:0] loc_out;
	psm_host_out_t [`PSM_NUM_CHAN-1:0] host_out_reg;

	for (genvar g = 0; g < `PSM_NUM_EXP; g++) begin : g_exp
		psm_expander u_exp (
			.sys_clk           (sys_clk),
			.rst_n             (rst_sync_n_reg),
			.port_code         (port_code_w),
			.board_granted     (granted && board_w == 2'(g + 1)),
			.host_in           (hin_sync_reg[3 + 4 * g +: 4]),
			.read_out          (rd_out),
			.port_enable_n     (),
			.port_request_line (exp_req[g]),
			.selected          (exp_sel[g]),
			.host_out          (exp_out[g])
		);
	end

	// Local ports see read data and acknowledge only when enabled.
	for (genvar g = 0; g < `PSM_LOCAL_PORTS; g++) begin : g_loc
		assign loc_out[g] = loc_en_w[g] ? rd_out : '0;
	end

	////////////////////////////////////////////////////////////////////
	// Write path: nibble assembly, buffer and controller strobe.

	logic         wr_strobe_d_reg;
	logic [3:0]   wr_low_reg;
	logic         wr_rise;
	logic         wr_fall;
	logic         fifo_out_valid;
	logic         wr_handshake;
	psm_wr_word_t fifo_in_word;
	psm_wr_word_t fifo_out_word;
	logic [7:0]   disk_write_byte_reg;
	logic         write_parity_bit_reg;
	logic         ctl_wr_strobe_reg;

	// First half carries bits 0-3, second half bits 4-7.
	assign wr_rise = granted && sel_host.host_write_strobe &&
		!wr_strobe_d_reg;
	assign wr_fall = granted && !sel_host.host_write_strobe &&
		wr_strobe_d_reg;
	assign fifo_in_word = {sel_host.write_parity_bit,
		sel_host.host_write_nibble, wr_low_reg};
	assign wr_handshake = fifo_out_valid && ctl_sync_reg.controller_write_ready;

	// Low nibble is taken at the start of the strobe.
	always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			wr_strobe_d_reg <= 1'b0;
			wr_low_reg      <= 4'h0;
		end else begin
			wr_strobe_d_reg <= granted && sel_host.host_write_strobe;
			if (wr_rise) begin
				wr_low_reg <= sel_host.host_write_nibble;
			end
		end
	end

	psm_fifo #(
		.WIDTH ($bits(psm_wr_word_t)),
		.DEPTH (`PSM_FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_sync_n_reg),
		.in_valid  (wr_fall),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_word),
		.out_valid (fifo_out_valid),
		.out_ready (ctl_sync_reg.controller_write_ready),
		.out_data  (fifo_out_word)
	);

	// Each drained byte gives one write strobe to the controller.
	always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			disk_write_byte_reg  <= 8'h00;
			write_parity_bit_reg <= 1'b0;
			ctl_wr_strobe_reg    <= 1'b0;
		end else begin
			ctl_wr_strobe_reg <= wr_handshake;
			if (wr_handshake) begin
				disk_write_byte_reg  <= fifo_out_word.byte_val;
				write_parity_bit_reg <= fifo_out_word.write_parity_bit;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registered outputs toward controller, expanders and hosts.

	logic       controller_prime_reg;
	logic       controller_host_status_reg;
	logic       second_drive_flag_reg;
	logic [3:0] board_select_line_reg;
	logic [1:0] port_code_reg;
	logic [2:0] local_port_enable_n_reg;

	// Status and decode follow the grant one clock later.
	always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			controller_prime_reg       <= 1'b0;
			controller_host_status_reg <= 1'b0;
			second_drive_flag_reg      <= 1'b0;
			board_select_line_reg      <= 4'h0;
			port_code_reg              <= 2'h0;
			local_port_enable_n_reg    <= 3'h7;
			host_out_reg               <= '0;
		end else begin
			controller_prime_reg <= prime;
			controller_host_status_reg <=
				granted && sel_host.processor_busy;
			second_drive_flag_reg <=
				granted && sel_host.second_drive_flag;
			board_select_line_reg <= granted ?
				(4'h1 << board_w) : 4'h0;
			port_code_reg           <= port_code_w;
			local_port_enable_n_reg <= ~loc_en_w;
			host_out_reg <= {exp_out[2], exp_out[1], exp_out[0],
				loc_out};
		end
	end

	assign host_out               = host_out_reg;
	assign controller_prime       = controller_prime_reg;
	assign controller_host_status = controller_host_status_reg;
	assign second_drive_flag      = second_drive_flag_reg;
	assign disk_write_byte        = disk_write_byte_reg;
	assign write_parity_bit       = write_parity_bit_reg;
	assign controller_write_strobe = ctl_wr_strobe_reg;
	assign board_select_line      = board_select_line_reg;
	assign port_code              = port_code_reg;
	assign local_port_enable_n    = local_port_enable_n_reg;

	////////////////////////////////////////////////////////////////////
	// Checks on poller, decode and nibble paths.

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_sync_n_reg);

	sequence s_wr_rise;
		wr_rise;
	endsequence
	sequence s_wr_fall;
		wr_fall;
	endsequence

	a_ack_owner: assert property (granted |=>
		host_out_reg[$past(chan_reg)].ack)
		else $error("Granted port did not see its acknowledge.");
	a_grant_hold: assert property (granted && req_all[chan_reg] && !prime
		|=> granted && $stable(chan_reg))
		else $error("Poller moved during a grant.");
	a_rr_next: assert property (granted && !req_all[chan_reg] && !prime
		|=> !granted && chan_reg == next_chan($past(chan_reg)))
		else $error("Scan did not resume at next channel.");
	a_prime_first: assert property (prime
		|=> chan_reg == `PSM_FIRST_CHAN && !granted)
		else $error("Prime did not return poller to first channel.");
	a_poll_step: assert property (!granted && !req_all[chan_reg] && !prime
		|=> chan_reg == next_chan($past(chan_reg)))
		else $error("Idle poller did not step one channel.");
	a_board_sel: assert property (granted
		|=> $onehot(board_select_line_reg))
		else $error("Board select not one of four under grant.");
	a_local_enable: assert property (granted && chan_reg < `PSM_LOCAL_PORTS
		|=> $countones(~local_port_enable_n_reg) == 1)
		else $error("Local enables wrong for a master port grant.");
	a_prime_out: assert property (prime |=> controller_prime)
		else $error("Host reset not passed on as prime.");
	a_read_halves: assert property (rd_rise |=>
		(rd_nib == rd_byte_reg[3:0] && rd_active)[*4]
		##1 (rd_nib == rd_byte_reg[7:4] && rd_active))
		else $error("Read nibble order wrong within strobe.");
	a_write_pack: assert property ((s_wr_rise ##1 (!wr_fall)[*2]
		##1 s_wr_fall) |-> fifo_in_word.byte_val[3:0] == $past(
		sel_host.host_write_nibble, 3))
		else $error("Low write nibble not from first half.");

endmodule // psm_mux_top

// ===== psm_disk_model.sv
// Disk controller model seen from the multiplexer's controller side.
module psm_disk_model (
	input  logic       sys_clk,
	output logic       controller_read_strobe,
	output logic [7:0] read_byte_bus,
	output logic       controller_ready_busy,
	output logic       controller_write_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle controller: no strobe, ready for write bytes.
	initial begin
		controller_read_strobe = 1'b0;
		read_byte_bus = 8'h00;
		controller_ready_busy = 1'b0;
		controller_write_ready = 1'b1;
	end

	// Byte stays stable under the strobe, then the bus turns to garbage.
	task automatic read_byte(input logic [7:0] b);
		@(posedge sys_clk);
		read_byte_bus <= b;
		controller_read_strobe <= 1'b1;
		repeat (6) @(posedge sys_clk);
		controller_read_strobe <= 1'b0;
		read_byte_bus <= ~b;
		repeat (6) @(posedge sys_clk);
	endtask
endmodule // psm_disk_model

// ===== testbench.sv
// Self-checking bench for the multiplexer master board.
`include "psm_regs.svh"
module testbench
	import psm_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst_n;
	psm_host_in_t  [`PSM_NUM_CHAN-1:0] host_in;
	psm_host_out_t [`PSM_NUM_CHAN-1:0] host_out;
	logic       controller_read_strobe, controller_ready_busy;
	logic       controller_write_ready, write_parity_bit;
	logic [7:0] read_byte_bus, disk_write_byte;
	logic       controller_prime, controller_host_status;
	logic       second_drive_flag, controller_write_strobe;
	logic [3:0] board_select_line;
	logic [1:0] port_code;
	logic [2:0] local_port_enable_n;
	int bad_count = 0;
	int check_count = 0;

	psm_mux_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .host_in(host_in),
		.controller_read_strobe(controller_read_strobe),
		.read_byte_bus(read_byte_bus),
		.controller_ready_busy(controller_ready_busy),
		.controller_write_ready(controller_write_ready),
		.host_out(host_out), .controller_prime(controller_prime),
		.controller_host_status(controller_host_status),
		.second_drive_flag(second_drive_flag),
		.disk_write_byte(disk_write_byte),
		.write_parity_bit(write_parity_bit),
		.controller_write_strobe(controller_write_strobe),
		.board_select_line(board_select_line), .port_code(port_code),
		.local_port_enable_n(local_port_enable_n));
	psm_disk_model pm_u (.sys_clk(sys_clk),
		.controller_read_strobe(controller_read_strobe),
		.read_byte_bus(read_byte_bus),
		.controller_ready_busy(controller_ready_busy),
		.controller_write_ready(controller_write_ready));

	// Free-running 40 MHz clock.
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
		end
	endtask

	// Waits a bounded time for a grant, then checks the decoded outputs.
	task automatic grant(input int c);
		int ch;
		int b;
		ch = -1;
		b = (c < 3) ? 0 : (c - 3) / 4 + 1;
		for (int i = 0; i < 60 && ch < 0; i++) begin
			@(negedge sys_clk);
			foreach (host_out[k]) if (host_out[k].ack === 1'b1) ch = k;
		end
		if (ch < 0) begin
			bad_count++;
			$display("wrong value at %0t: no grant", $time);
			finish_test();
		end
		chk(8'(ch), 8'(c), "port");
		chk(8'(board_select_line), 8'(1 << b), "board");
		chk(8'(port_code), 8'((c < 3) ? c : (c - 3) % 4), "code");
		chk(8'(local_port_enable_n), (c < 3) ? 8'(3'(~(3'h1 << c))) : 8'h07,
			"enables");
	endtask

	// Host ends its operation by dropping its request.
	task automatic release_port(input int c);
		@(posedge sys_clk);
		host_in[c].port_request <= 1'b0;
		repeat (8) @(negedge sys_clk);
		chk(8'(host_out[c].ack), 8'h00, "ack drop");
	endtask

	// Order of service from reset, round robin, and holding of a grant.
	task automatic t_poll;
		grant(6);
		release_port(6);
		grant(14);
		@(posedge sys_clk);
		host_in[2].port_request <= 1'b1;
		host_in[12].port_request <= 1'b1;
		release_port(14);
		grant(2);
		repeat (20) @(negedge sys_clk);
		chk(8'({host_out[2].ack, host_out[12].ack}), 8'h02, "hold");
		release_port(2);
		grant(12);
	endtask

	// Read byte reaches the granted host low nibble first.
	task automatic t_read;
		int n;
		n = 0;
		fork
			pm_u.read_byte(8'ha5);
			while (host_out[12].host_read_strobe !== 1'b1 && n++ < 20)
				@(negedge sys_clk);
		join_any
		if (n > 20) begin
			bad_count++;
			$display("wrong value at %0t: no read strobe", $time);
			finish_test();
		end
		chk(8'(host_out[12].host_read_nibble), 8'h05, "low nib");
		chk(8'(host_out[0].host_read_nibble), 8'h00, "idle port");
		repeat (4) @(negedge sys_clk);
		chk(8'(host_out[12].host_read_nibble), 8'h0a, "high nib");
		wait fork;
	endtask

	// Write byte is held while the controller stalls, then delivered.
	task automatic t_write;
		int n;
		n = 0;
		@(posedge sys_clk);
		pm_u.controller_write_ready <= 1'b0;
		host_in[12].host_write_nibble <= 4'h6;
		host_in[12].host_write_strobe <= 1'b1;
		repeat (3) @(posedge sys_clk);
		host_in[12].host_write_nibble <= 4'h9;
		host_in[12].write_parity_bit <= 1'b1;
		host_in[12].host_write_strobe <= 1'b0;
		repeat (10) @(negedge sys_clk) n += controller_write_strobe;
		chk(8'(n), 8'h00, "stall");
		@(posedge sys_clk);
		pm_u.controller_write_ready <= 1'b1;
		n = 0;
		do @(negedge sys_clk);
		while (controller_write_strobe !== 1'b1 && n++ < 20);
		if (n > 20) begin
			bad_count++;
			$display("wrong value at %0t: no write strobe", $time);
			finish_test();
		end
		chk(disk_write_byte, 8'h96, "write byte");
		chk(8'(write_parity_bit), 8'h01, "parity");
	endtask

	// Status lines follow the granted host and the controller.
	task automatic t_status;
		int n;
		n = 0;
		for (int v = 1; v >= 0; v--) begin
			@(posedge sys_clk);
			host_in[12].processor_busy <= v[0];
			host_in[12].second_drive_flag <= v[0];
			pm_u.controller_ready_busy <= v[0];
			repeat (6) @(negedge sys_clk);
			chk(8'(controller_host_status), 8'(v), "busy");
			chk(8'(second_drive_flag), 8'(v), "drive");
			chk(8'(host_out[12].host_disk_ready_busy), 8'(v), "rb");
		end
		@(posedge sys_clk);
		host_in[12].reset_pulse <= 1'b1;
		// Prime restarts the poller, so it shows as a single-cycle pulse.
		repeat (6) @(negedge sys_clk) n += controller_prime;
		chk(8'(n), 8'h01, "prime");
	endtask

	// Main sequence: hosts request before reset ends, then all scenarios.
	initial begin
		rst_n = 1'b0;
		host_in = '0;
		host_in[6].port_request = 1'b1;
		host_in[14].port_request = 1'b1;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_poll();
		t_read();
		t_write();
		t_status();
		finish_test();
	end
endmodule // testbench
